// file: cmul_pkg.sv
// Constants for the clock multiplier control register and its sequencing
package cmul_pkg;

    // Register location and width
    localparam logic [7:0] CMUL_CTRL_ADDR    = 8'h00_AB;
    localparam int         CMUL_DATA_W       = 8;
    localparam logic [7:0] CMUL_CTRL_RESET   = 8'h00_00;

    // Field positions
    localparam int         CMUL_ON_BIT       = 7;
    localparam int         CMUL_KICK_BIT     = 6;
    localparam int         CMUL_LOCKED_BIT   = 5;
    localparam int         CMUL_SCALE_MSB    = 4;
    localparam int         CMUL_SCALE_LSB    = 2;
    localparam int         CMUL_PICK_MSB     = 1;
    localparam int         CMUL_PICK_LSB     = 0;

    // Scale and pick codes
    localparam logic [2:0] CMUL_SCALE_DIV3   = 3'h3;
    localparam logic [1:0] CMUL_PICK_OSC_HALF = 2'h0;

    // Lock time of the multiplier after initialization
    localparam int         CMUL_CLK_MHZ      = 100;
    localparam int         CMUL_LOCK_TIME_NS = 2000;
    localparam int         CMUL_LOCK_CYCLES  = (CMUL_LOCK_TIME_NS * CMUL_CLK_MHZ + 999) / 1000;
    localparam int         CMUL_LOCK_CNT_W   = 16;

    // Control sequencer states
    typedef enum logic [1:0]
    {
        CMUL_OFF     = 2'b00,
        CMUL_ON      = 2'b01,
        CMUL_LOCKING = 2'b10,
        CMUL_LOCKED  = 2'b11
    } cmul_state_e;

endpackage

// file: cmul_scaler.sv
// Output scaler producing core clock enables at 1 or 2/N of the multiplier rate
`timescale 1ns/1ps
module cmul_scaler
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // Control
    input  wire logic       run,
    input  wire logic [2:0] scale_code,
    // Scaled output
    output logic            core_clk_en
);
    import cmul_pkg::*;

    logic [2:0] acc_q;
    logic [2:0] acc_d;
    logic       tick_q;
    logic       tick_d;
    logic [3:0] sum;
    logic [3:0] modulus;

    // Adds two per input cycle, ticks on every wrap past N
    always_comb
    begin
        modulus = {1'b0, scale_code};
        sum     = {1'b0, acc_q} + 4'h2;
        acc_d   = acc_q;
        tick_d  = 1'b0;
        if (!run)
        begin
            acc_d = 3'h0;
        end
        else if (scale_code < CMUL_SCALE_DIV3)
        begin
            acc_d  = 3'h0;
            tick_d = 1'b1;
        end
        else if (sum >= modulus)
        begin
            acc_d  = 3'(sum - modulus);
            tick_d = 1'b1;
        end
        else
        begin
            acc_d = sum[2:0];
        end
    end

    // Odd divisors give an uneven tick pattern and so an uneven duty cycle
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            acc_q  <= 3'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            acc_q  <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign core_clk_en = tick_q;

endmodule // cmul_scaler

// file: cmul_ctrl.sv
// Clock multiplier control register, lock sequencing and output scaling
`timescale 1ns/1ps
module cmul_ctrl
(
    // Clock and reset
    input  wire logic                           clock,
    input  wire logic                           reset,
    // Special-function register port
    input  wire logic [7:0]                     sfr_addr,
    input  wire logic                           sfr_wr,
    input  wire logic                           sfr_rd,
    input  wire logic [cmul_pkg::CMUL_DATA_W-1:0] sfr_wdata,
    output logic      [cmul_pkg::CMUL_DATA_W-1:0] sfr_rdata,
    // Analog multiplier controls
    output logic                                mult_enable,
    output logic                                mult_init,
    output logic      [1:0]                     mult_src_sel,
    output logic                                mult_src_osc_half,
    // Scaled core clock enable and lock status
    output logic                                core_clk_en,
    output logic                                multiplier_locked
);
    import cmul_pkg::*;

    // Register fields
    logic                          on_q;
    logic                          on_d;
    logic                          kick_q;
    logic                          kick_d;
    logic [2:0]                    scale_q;
    logic [2:0]                    scale_d;
    logic [1:0]                    pick_q;
    logic [1:0]                    pick_d;
    logic [CMUL_DATA_W-1:0]        rdata_q;
    logic [CMUL_DATA_W-1:0]        rdata_d;

    // Sequencer
    cmul_state_e                   state_q;
    cmul_state_e                   state_d;
    logic [CMUL_LOCK_CNT_W-1:0]    lock_cnt_q;
    logic [CMUL_LOCK_CNT_W-1:0]    lock_cnt_d;
    logic                          init_q;
    logic                          init_d;

    // Decode
    logic                          wr_hit;
    logic                          rd_hit;
    logic                          kick_req;
    logic                          locked;
    logic [CMUL_DATA_W-1:0]        ctrl_view;

    assign wr_hit   = sfr_wr && (sfr_addr == CMUL_CTRL_ADDR);
    assign rd_hit   = sfr_rd && (sfr_addr == CMUL_CTRL_ADDR);
    // Kick only counts when the multiplier was already on before this write
    assign kick_req = wr_hit && sfr_wdata[CMUL_KICK_BIT] && on_q
                      && sfr_wdata[CMUL_ON_BIT];
    assign locked   = (state_q == CMUL_LOCKED);

    // Read view; locked bit reflects sequencer, never stored from a write
    always_comb
    begin
        ctrl_view                                 = CMUL_CTRL_RESET;
        ctrl_view[CMUL_ON_BIT]                    = on_q;
        ctrl_view[CMUL_KICK_BIT]                  = kick_q;
        ctrl_view[CMUL_LOCKED_BIT]                = locked;
        ctrl_view[CMUL_SCALE_MSB:CMUL_SCALE_LSB]  = scale_q;
        ctrl_view[CMUL_PICK_MSB:CMUL_PICK_LSB]    = pick_q;
    end

    // Register write and read
    always_comb
    begin
        on_d    = on_q;
        kick_d  = kick_q;
        scale_d = scale_q;
        pick_d  = pick_q;
        rdata_d = rdata_q;
        if (wr_hit)
        begin
            on_d    = sfr_wdata[CMUL_ON_BIT];
            kick_d  = sfr_wdata[CMUL_KICK_BIT];
            scale_d = sfr_wdata[CMUL_SCALE_MSB:CMUL_SCALE_LSB];
            pick_d  = sfr_wdata[CMUL_PICK_MSB:CMUL_PICK_LSB];
        end
        // Reads of other addresses return zero
        if (rd_hit)
        begin
            rdata_d = ctrl_view;
        end
        else if (sfr_rd)
        begin
            rdata_d = CMUL_CTRL_RESET;
        end
    end

    // Field registers and read data
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            on_q    <= 1'b0;
            kick_q  <= 1'b0;
            scale_q <= 3'h0;
            pick_q  <= 2'h0;
            rdata_q <= CMUL_CTRL_RESET;
        end
        else
        begin
            on_q    <= on_d;
            kick_q  <= kick_d;
            scale_q <= scale_d;
            pick_q  <= pick_d;
            rdata_q <= rdata_d;
        end
    end

    // Enable, initialize and lock sequencing
    always_comb
    begin
        state_d    = state_q;
        lock_cnt_d = lock_cnt_q;
        init_d     = 1'b0;
        unique case (state_q)
            CMUL_OFF:
            begin
                // Kick in the cycle right after enabling still counts
                if (kick_req)
                begin
                    state_d    = CMUL_LOCKING;
                    lock_cnt_d = CMUL_LOCK_CNT_W'(CMUL_LOCK_CYCLES);
                    init_d     = 1'b1;
                end
                else if (on_q)
                begin
                    state_d = CMUL_ON;
                end
            end
            CMUL_ON:
            begin
                if (kick_req)
                begin
                    state_d    = CMUL_LOCKING;
                    lock_cnt_d = CMUL_LOCK_CNT_W'(CMUL_LOCK_CYCLES);
                    init_d     = 1'b1;
                end
            end
            CMUL_LOCKING:
            begin
                if (lock_cnt_q > CMUL_LOCK_CNT_W'(1))
                begin
                    lock_cnt_d = lock_cnt_q - CMUL_LOCK_CNT_W'(1);
                end
                else
                begin
                    lock_cnt_d = '0;
                    state_d    = CMUL_LOCKED;
                end
            end
            CMUL_LOCKED:
            begin
                // A fresh kick restarts the lock sequence
                if (kick_req)
                begin
                    state_d    = CMUL_LOCKING;
                    lock_cnt_d = CMUL_LOCK_CNT_W'(CMUL_LOCK_CYCLES);
                    init_d     = 1'b1;
                end
            end
        endcase
        // Disable drops lock at once
        if (!on_q)
        begin
            state_d    = CMUL_OFF;
            lock_cnt_d = '0;
            init_d     = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_q    <= CMUL_OFF;
            lock_cnt_q <= '0;
            init_q     <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            lock_cnt_q <= lock_cnt_d;
            init_q     <= init_d;
        end
    end

    // Scaled core clock enable, running only while enabled
    cmul_scaler u_scaler
    (
        .clock       (clock),
        .reset       (reset),
        .run         (on_q),
        .scale_code  (scale_q),
        .core_clk_en (core_clk_en)
    );

    // Outputs
    assign sfr_rdata         = rdata_q;
    assign mult_enable       = on_q;
    assign mult_init         = init_q;
    assign mult_src_sel      = pick_q;
    assign mult_src_osc_half = (pick_q == CMUL_PICK_OSC_HALF);
    assign multiplier_locked = locked;

endmodule // cmul_ctrl

// file: cmul_properties.sv
// Concurrent checks on the clock multiplier control ports
`timescale 1ns/1ps
module cmul_props
(
    // Clock and reset
    input wire logic                               clock,
    input wire logic                               reset,
    // Register port
    input wire logic [7:0]                         sfr_addr,
    input wire logic                               sfr_wr,
    input wire logic                               sfr_rd,
    input wire logic [cmul_pkg::CMUL_DATA_W-1:0]   sfr_wdata,
    input wire logic [cmul_pkg::CMUL_DATA_W-1:0]   sfr_rdata,
    // Multiplier side
    input wire logic                               mult_enable,
    input wire logic                               mult_init,
    input wire logic [1:0]                         mult_src_sel,
    input wire logic                               mult_src_osc_half,
    input wire logic                               core_clk_en,
    input wire logic                               multiplier_locked
);
    import cmul_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic wr_hit;
    assign wr_hit = sfr_wr && sfr_addr == CMUL_CTRL_ADDR;
    en_follow_a:
    assert property (wr_hit |=> mult_enable == $past(sfr_wdata[7])) else $error("enable bit not applied");
    kick_start_a:
    assert property (wr_hit && sfr_wdata[7:6] == 2'b11 && mult_enable |=> mult_init) else $error("kick missed");
    kick_off_a:
    assert property (sfr_wr && !mult_enable |=> !mult_init) else $error("kick while off");
    init_pulse_a:
    assert property (mult_init |=> !mult_init) else $error("init pulse too long");
    lock_wait_a:
    assert property (mult_init |=> (!multiplier_locked)[*8]) else $error("locked too early");
    lock_late_a:
    assert property ($rose(multiplier_locked) |-> $past(mult_init, 200) || $past(mult_init, 201))
        else $error("lock time wrong");
    off_unlock_a:
    assert property ((!mult_enable)[*3] |-> !multiplier_locked && !core_clk_en) else $error("active while off");
    pick_store_a:
    assert property (wr_hit |=> mult_src_sel == $past(sfr_wdata[1:0])) else $error("pick not stored");
    osc_half_a:
    assert property (mult_src_osc_half == (mult_src_sel == 2'b00)) else $error("source decode wrong");
    status_read_a:
    assert property (sfr_rd && sfr_addr == CMUL_CTRL_ADDR |=> sfr_rdata[5] == $past(multiplier_locked))
        else $error("status read wrong");
    cover property (mult_init);
    cover property ($rose(multiplier_locked));
    cover property (sfr_rd && sfr_addr != CMUL_CTRL_ADDR);
endmodule // cmul_props
bind cmul_ctrl cmul_props u_props (.clock(clock), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mult_enable(mult_enable),
    .mult_init(mult_init), .mult_src_sel(mult_src_sel), .mult_src_osc_half(mult_src_osc_half),
    .core_clk_en(core_clk_en), .multiplier_locked(multiplier_locked));

// file: testbench.sv
// Self-checking bench for the clock multiplier control register
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
    import cmul_pkg::*;
    logic       clock = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, rd_seen = 0;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, exp_v;
    logic       mult_enable, mult_init, mult_src_osc_half, core_clk_en, multiplier_locked;
    logic [1:0] mult_src_sel, pick;
    logic [7:0] exp_q[$];
    int         error_cnt = 0, num_checks = 0;
    logic [15:0] cnt;
    int         exp_cnt[8] = '{210, 210, 210, 140, 105, 84, 70, 60};
    cmul_ctrl DUT (.clock(clock), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mult_enable(mult_enable), .mult_init(mult_init),
        .mult_src_sel(mult_src_sel), .mult_src_osc_half(mult_src_osc_half), .core_clk_en(core_clk_en),
        .multiplier_locked(multiplier_locked));
    always #5 clock = ~clock;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1;
        @(negedge clock);
        sfr_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        sfr_addr = a;
        sfr_rd = 1;
        exp_q.push_back(e);
        @(negedge clock);
        sfr_rd = 0;
    endtask
    // Enable pulses over 210 cycles, a whole number of periods of every pattern
    task automatic count(output logic [15:0] n);
        n = 0;
        repeat (8) @(negedge clock);
        repeat (210)
        begin
            @(negedge clock);
            n += core_clk_en;
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clock)
    begin
        if (rd_seen)
        begin
            exp_v = exp_q.pop_front();
            `CHK("sfr_rdata", exp_v, sfr_rdata)
        end
        rd_seen <= sfr_rd;
    end
    initial
    begin
        #200us;
        error_cnt++;
        stop_test();
    end
    initial
    begin
        void'($urandom(32'hd428));
        repeat (3) @(negedge clock);
        reset = 0;
        rd(CMUL_CTRL_ADDR, CMUL_CTRL_RESET);
        for (int c = 0; c < 8; c++)
        begin
            pick = 2'($urandom);
            wr(CMUL_CTRL_ADDR, {3'b101, c[2:0], pick});
            rd(CMUL_CTRL_ADDR, {3'b100, c[2:0], pick});
            `CHK("mult_src_sel", pick, mult_src_sel)
            `CHK("mult_src_osc_half", pick == CMUL_PICK_OSC_HALF, mult_src_osc_half)
            `CHK("mult_enable", 1'b1, mult_enable)
            count(cnt);
            `CHK("core_clk_en rate", exp_cnt[c], cnt)
        end
        wr(CMUL_CTRL_ADDR, 8'h00_00);
        wr(CMUL_CTRL_ADDR, 8'h00_C0);
        repeat (501) @(negedge clock);
        `CHK("locked after early kick", 1'b0, multiplier_locked)
        wr(CMUL_CTRL_ADDR, 8'h00_C0);
        `CHK("mult_init", 1'b1, mult_init)
        repeat (199) @(negedge clock);
        `CHK("locked during lock wait", 1'b0, multiplier_locked)
        repeat (2) @(negedge clock);
        `CHK("locked after lock wait", 1'b1, multiplier_locked)
        rd(CMUL_CTRL_ADDR, 8'h00_E0);
        wr(8'h00_AA, 8'h00_00);
        rd(8'h00_AA, 8'h00_00);
        rd(CMUL_CTRL_ADDR, 8'h00_E0);
        wr(CMUL_CTRL_ADDR, 8'h00_00);
        repeat (3) @(negedge clock);
        `CHK("locked after disable", 1'b0, multiplier_locked)
        count(cnt);
        `CHK("core_clk_en while off", 0, cnt)
        rd(CMUL_CTRL_ADDR, 8'h00_00);
        repeat (3) @(negedge clock);
        stop_test();
    end
endmodule // testbench
